/* verilog/psc_pkg.sv */
// Summary of operation
// - accumulate transmitted bytes per port
// - count tx unicast, multicast, broadcast frames
// - count frames aged out in transit
// - count tx discards for bad fcs
// - count tx drops after retry limit
// - count tx success after one collision
// - count tx success after several collisions
// - count tx discards from underrun
// - accumulate received bytes per port
// - count good drops: buffer full, memory full
// - count aligned rx frames with bad fcs
// - count rx unicast, multicast, broadcast frames
// - count error-free oversized rx frames
// - count errored oversized rx frames separately
// - count error-free undersized rx frames
// - count errored undersized rx frames separately
// - six-bin rx length histogram, errors included
// - count only while enabled; enabled after reset
package psc_pkg;

  localparam int          NUM_PORTS  = 8;
  localparam int          PORT_W     = 3;
  localparam int          CNT_W      = 32;
  localparam int          LEN_W      = 11;
  localparam int          COL_W      = 4;
  localparam int          NUM_CNT    = 27;
  localparam int          IDX_W      = 5;

  // ---------------------------------------------------------------
  // frame length limits
  // ---------------------------------------------------------------
  localparam logic [10:0] LEN_MIN    = 11'h040;
  localparam logic [10:0] LEN_127    = 11'h07f;
  localparam logic [10:0] LEN_255    = 11'h0ff;
  localparam logic [10:0] LEN_511    = 11'h1ff;
  localparam logic [10:0] LEN_1023   = 11'h3ff;
  localparam logic [10:0] LEN_MAX    = 11'h5ee;

  localparam logic        STATS_EN_RESET = 1'b1;
  localparam logic [31:0] CNT_RESET      = 32'h0000_0000;

  // ---------------------------------------------------------------
  // counter index map within one port's set
  // ---------------------------------------------------------------
  localparam logic [4:0]  C_TX_BYTES   = 5'h00;
  localparam logic [4:0]  C_TX_UNI     = 5'h01;
  localparam logic [4:0]  C_TX_MULTI   = 5'h02;
  localparam logic [4:0]  C_TX_BCAST   = 5'h03;
  localparam logic [4:0]  C_TX_AGED    = 5'h04;
  localparam logic [4:0]  C_TX_FCS     = 5'h05;
  localparam logic [4:0]  C_TX_RETRY   = 5'h06;
  localparam logic [4:0]  C_TX_ONE_COL = 5'h07;
  localparam logic [4:0]  C_TX_MUL_COL = 5'h08;
  localparam logic [4:0]  C_TX_UNDERRUN = 5'h09;
  localparam logic [4:0]  C_RX_BYTES   = 5'h0a;
  localparam logic [4:0]  C_RX_BUF_FULL = 5'h0b;
  localparam logic [4:0]  C_RX_MEM_FULL = 5'h0c;
  localparam logic [4:0]  C_RX_FCS     = 5'h0d;
  localparam logic [4:0]  C_RX_UNI     = 5'h0e;
  localparam logic [4:0]  C_RX_MULTI   = 5'h0f;
  localparam logic [4:0]  C_RX_BCAST   = 5'h10;
  localparam logic [4:0]  C_RX_GOOD_OVER  = 5'h11;
  localparam logic [4:0]  C_RX_ERR_OVER   = 5'h12;
  localparam logic [4:0]  C_RX_GOOD_UNDER = 5'h13;
  localparam logic [4:0]  C_RX_ERR_UNDER  = 5'h14;
  localparam logic [4:0]  C_RX_BIN0    = 5'h15;

  typedef enum logic [1:0] {
    PSC_DEST_UNI,
    PSC_DEST_MULTI,
    PSC_DEST_BCAST
  } psc_dest_t;

  typedef enum logic [2:0] {
    PSC_TX_SENT,
    PSC_TX_AGED,
    PSC_TX_FCS_BAD,
    PSC_TX_RETRY_LIMIT,
    PSC_TX_UNDERRUN
  } psc_tx_status_t;

  typedef enum logic [1:0] {
    PSC_RX_KEPT,
    PSC_RX_DROP_BUF,
    PSC_RX_DROP_MEM
  } psc_rx_drop_t;

endpackage

/* verilog/psc_cls_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface psc_cls_if;
  logic [10:0] len;
  logic        errored;
  logic        oversize;
  logic        undersize;
  logic        bin_hit;
  logic [2:0]  bin;

  modport src (output len, input errored, oversize, undersize, bin_hit, bin);
  modport cls (input len, output errored, oversize, undersize, bin_hit, bin);
endinterface
`default_nettype wire

/* verilog/psc_len_class.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_len_class (
  psc_cls_if.cls            cls,
  input  wire logic         fcs_err_in,
  input  wire logic         align_err_in
);

  // -----------------------------------------------------------------
  // size class and histogram bin of one received frame
  // -----------------------------------------------------------------
  always_comb begin
    cls.errored   = fcs_err_in | align_err_in;
    cls.oversize  = cls.len > psc_pkg::LEN_MAX;
    cls.undersize = cls.len < psc_pkg::LEN_MIN;
    cls.bin_hit   = 1'b1;
    cls.bin       = 3'h0;
    // only an exact 64-byte frame lands in the first bin
    if (cls.len == psc_pkg::LEN_MIN) begin
      cls.bin = 3'h0;
    end else if (cls.len < psc_pkg::LEN_MIN) begin
      cls.bin_hit = 1'b0;
    end else if (cls.len <= psc_pkg::LEN_127) begin
      cls.bin = 3'h1;
    end else if (cls.len <= psc_pkg::LEN_255) begin
      cls.bin = 3'h2;
    end else if (cls.len <= psc_pkg::LEN_511) begin
      cls.bin = 3'h3;
    end else if (cls.len <= psc_pkg::LEN_1023) begin
      cls.bin = 3'h4;
    end else if (cls.len <= psc_pkg::LEN_MAX) begin
      cls.bin = 3'h5;
    end else begin
      cls.bin_hit = 1'b0;
    end
  end

endmodule
`default_nettype wire

/* verilog/psc_stats.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_stats (
  input  wire logic                   mclk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   ce_in,
  input  wire logic                   stats_enable_in,
  input  wire logic                   tx_done_in,
  input  wire logic [2:0]             tx_port_in,
  input  wire logic [10:0]            tx_len_in,
  input  wire psc_pkg::psc_dest_t     tx_dest_in,
  input  wire psc_pkg::psc_tx_status_t tx_status_in,
  input  wire logic [3:0]             tx_col_count_in,
  input  wire logic                   rx_done_in,
  input  wire logic [2:0]             rx_port_in,
  input  wire logic [10:0]            rx_len_in,
  input  wire psc_pkg::psc_dest_t     rx_dest_in,
  input  wire logic                   rx_fcs_err_in,
  input  wire logic                   rx_align_err_in,
  input  wire psc_pkg::psc_rx_drop_t  rx_drop_in,
  input  wire logic                   rd_req_in,
  input  wire logic [2:0]             rd_port_in,
  input  wire logic [4:0]             rd_index_in,
  output logic                        rd_valid_out,
  output logic [31:0]                 rd_data_out,
  output logic                        stats_active_out
);

  // -----------------------------------------------------------------
  // storage and per-event increments
  // -----------------------------------------------------------------
  logic [31:0] cnt_reg [psc_pkg::NUM_PORTS][psc_pkg::NUM_CNT];
  logic [31:0] tx_add  [psc_pkg::NUM_CNT];
  logic [31:0] rx_add  [psc_pkg::NUM_CNT];
  logic        stats_en_reg;
  logic        tx_sent;
  logic        rx_good;

  psc_cls_if cls_bus ();

  psc_len_class u_len_class (
    .cls          (cls_bus.cls),
    .fcs_err_in   (rx_fcs_err_in),
    .align_err_in (rx_align_err_in)
  );

  assign cls_bus.len = rx_len_in;

  function automatic logic [31:0] pulse(input logic hit);
    pulse = {31'h0000_0000, hit};
  endfunction

  // -----------------------------------------------------------------
  // statistics enable
  // -----------------------------------------------------------------
  // resets set so counting starts without any software action
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stats_en_reg <= psc_pkg::STATS_EN_RESET;
    end else if (ce_in) begin
      stats_en_reg <= stats_enable_in;
    end
  end

  // -----------------------------------------------------------------
  // transmit increments
  // -----------------------------------------------------------------
  assign tx_sent = tx_status_in == psc_pkg::PSC_TX_SENT;

  always_comb begin
    for (int i = 0; i < psc_pkg::NUM_CNT; i++) begin
      tx_add[i] = 32'h0000_0000;
    end
    if (tx_sent) begin
      tx_add[psc_pkg::C_TX_BYTES] = {21'h00_0000, tx_len_in};
    end
    tx_add[psc_pkg::C_TX_UNI] =
      pulse(tx_sent && tx_dest_in == psc_pkg::PSC_DEST_UNI);
    tx_add[psc_pkg::C_TX_MULTI] =
      pulse(tx_sent && tx_dest_in == psc_pkg::PSC_DEST_MULTI);
    tx_add[psc_pkg::C_TX_BCAST] =
      pulse(tx_sent && tx_dest_in == psc_pkg::PSC_DEST_BCAST);
    tx_add[psc_pkg::C_TX_AGED] =
      pulse(tx_status_in == psc_pkg::PSC_TX_AGED);
    tx_add[psc_pkg::C_TX_FCS] =
      pulse(tx_status_in == psc_pkg::PSC_TX_FCS_BAD);
    tx_add[psc_pkg::C_TX_RETRY] =
      pulse(tx_status_in == psc_pkg::PSC_TX_RETRY_LIMIT);
    tx_add[psc_pkg::C_TX_ONE_COL] =
      pulse(tx_sent && tx_col_count_in == 4'h1);
    tx_add[psc_pkg::C_TX_MUL_COL] =
      pulse(tx_sent && tx_col_count_in > 4'h1);
    tx_add[psc_pkg::C_TX_UNDERRUN] =
      pulse(tx_status_in == psc_pkg::PSC_TX_UNDERRUN);
  end

  // -----------------------------------------------------------------
  // receive increments
  // -----------------------------------------------------------------
  // a frame counts as good when it has neither fcs nor alignment error
  assign rx_good = !cls_bus.errored;

  always_comb begin
    for (int i = 0; i < psc_pkg::NUM_CNT; i++) begin
      rx_add[i] = 32'h0000_0000;
    end
    // every arriving byte counts, dropped or errored frames included
    rx_add[psc_pkg::C_RX_BYTES] = {21'h00_0000, rx_len_in};
    rx_add[psc_pkg::C_RX_BUF_FULL] =
      pulse(rx_good && rx_drop_in == psc_pkg::PSC_RX_DROP_BUF);
    rx_add[psc_pkg::C_RX_MEM_FULL] =
      pulse(rx_good && rx_drop_in == psc_pkg::PSC_RX_DROP_MEM);
    rx_add[psc_pkg::C_RX_FCS] =
      pulse(rx_fcs_err_in && !rx_align_err_in);
    rx_add[psc_pkg::C_RX_UNI] =
      pulse(rx_good && rx_dest_in == psc_pkg::PSC_DEST_UNI);
    rx_add[psc_pkg::C_RX_MULTI] =
      pulse(rx_good && rx_dest_in == psc_pkg::PSC_DEST_MULTI);
    rx_add[psc_pkg::C_RX_BCAST] =
      pulse(rx_good && rx_dest_in == psc_pkg::PSC_DEST_BCAST);
    rx_add[psc_pkg::C_RX_GOOD_OVER] =
      pulse(cls_bus.oversize && rx_good);
    rx_add[psc_pkg::C_RX_ERR_OVER] =
      pulse(cls_bus.oversize && cls_bus.errored);
    rx_add[psc_pkg::C_RX_GOOD_UNDER] =
      pulse(cls_bus.undersize && rx_good);
    rx_add[psc_pkg::C_RX_ERR_UNDER] =
      pulse(cls_bus.undersize && cls_bus.errored);
    for (int b = 0; b < 6; b++) begin
      rx_add[int'(psc_pkg::C_RX_BIN0) + b] =
        pulse(cls_bus.bin_hit && cls_bus.bin == 3'(b));
    end
  end

  // -----------------------------------------------------------------
  // counter array
  // -----------------------------------------------------------------
  // tx and rx touch disjoint indices, so one port may take both
  // events in the same cycle without losing either
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int p = 0; p < psc_pkg::NUM_PORTS; p++) begin
        for (int i = 0; i < psc_pkg::NUM_CNT; i++) begin
          cnt_reg[p][i] <= psc_pkg::CNT_RESET;
        end
      end
    end else if (ce_in && stats_en_reg) begin
      for (int p = 0; p < psc_pkg::NUM_PORTS; p++) begin
        for (int i = 0; i < psc_pkg::NUM_CNT; i++) begin
          if (tx_done_in && tx_port_in == 3'(p) && rx_done_in && rx_port_in == 3'(p)) begin
            cnt_reg[p][i] <= cnt_reg[p][i] + tx_add[i] + rx_add[i];
          end else if (tx_done_in && tx_port_in == 3'(p)) begin
            cnt_reg[p][i] <= cnt_reg[p][i] + tx_add[i];
          end else if (rx_done_in && rx_port_in == 3'(p)) begin
            cnt_reg[p][i] <= cnt_reg[p][i] + rx_add[i];
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  // the value returned is the count before any same-cycle update
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 32'h0000_0000;
    end else if (ce_in) begin
      rd_valid_out <= rd_req_in;
      if (rd_req_in) begin
        if (int'(rd_index_in) < psc_pkg::NUM_CNT) begin
          rd_data_out <= cnt_reg[rd_port_in][rd_index_in];
        end else begin
          rd_data_out <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stats_active_out <= 1'b0;
    end else if (ce_in) begin
      stats_active_out <= stats_en_reg;
    end
  end

endmodule
`default_nettype wire

/* sim/psc_stats_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_stats_asserts (
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic        ce_in,
  input wire logic        stats_enable_in,
  input wire logic        rd_req_in,
  input wire logic [4:0]  rd_index_in,
  input wire logic        rd_valid_out,
  input wire logic [31:0] rd_data_out,
  input wire logic        stats_active_out
);
  // ---------------------------------------------------------------
  // read port and enable checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  // a request only counts on an edge with ce_in high
  wire logic take = ce_in && rd_req_in;

  a_read_answer: assert property (take |=> rd_valid_out)
    else $error("read not answered");
  a_valid_cause: assert property (ce_in && !rd_req_in |=> !rd_valid_out)
    else $error("valid without request");
  a_data_hold: assert property (!rd_valid_out |-> $stable(rd_data_out))
    else $error("read data moved");
  a_bad_index: assert property (take && rd_index_in > 5'h1a |=> rd_data_out == 32'h0)
    else $error("bad index gave data");
  a_enable_off: assert property (ce_in && !stats_enable_in ##1 ce_in |=> !stats_active_out)
    else $error("still active");
  a_enable_on: assert property (ce_in && stats_enable_in ##1 ce_in |=> stats_active_out)
    else $error("not active");
  a_ce_freeze: assert property (!ce_in |=> $stable(rd_valid_out) && $stable(rd_data_out))
    else $error("moved while frozen");
  a_reset_clear: assert property ($rose(reset_n_in) |->
    rd_data_out == 32'h0 && !rd_valid_out)
    else $error("not cleared");
  c_bad_read: cover property (take && rd_index_in > 5'h1a);
  c_two_reads: cover property (take ##2 take);
  c_disable: cover property ($fell(stats_active_out));
endmodule

bind psc_stats psc_stats_asserts u_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .ce_in(ce_in), .stats_enable_in(stats_enable_in), .rd_req_in(rd_req_in),
  .rd_index_in(rd_index_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
  .stats_active_out(stats_active_out));
`default_nettype wire

/* sim/psc_mac_model.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_mac_model (
  input  wire logic                    clk_in,
  output var  logic                    tx_done_out,
  output var  logic [2:0]              tx_port_out,
  output var  logic [10:0]             tx_len_out,
  output var  psc_pkg::psc_dest_t      tx_dest_out,
  output var  psc_pkg::psc_tx_status_t tx_st_out,
  output var  logic [3:0]              tx_col_out,
  output var  logic                    rx_done_out,
  output var  logic [2:0]              rx_port_out,
  output var  logic [10:0]             rx_len_out,
  output var  psc_pkg::psc_dest_t      rx_dest_out,
  output var  logic                    rx_fcs_out,
  output var  logic                    rx_aln_out,
  output var  psc_pkg::psc_rx_drop_t   rx_drop_out
);
  // ---------------------------------------------------------------
  // frame event paths, one pulse per frame
  // ---------------------------------------------------------------
  initial begin
    {tx_done_out, tx_port_out, tx_len_out, tx_col_out} = '0;
    {rx_done_out, rx_port_out, rx_len_out, rx_fcs_out, rx_aln_out} = '0;
    tx_dest_out = psc_pkg::PSC_DEST_UNI;
    tx_st_out = psc_pkg::PSC_TX_SENT;
    rx_dest_out = psc_pkg::PSC_DEST_UNI;
    rx_drop_out = psc_pkg::PSC_RX_KEPT;
  end
  task automatic tx(input logic [2:0] p, input logic [10:0] l, input psc_pkg::psc_dest_t d,
                    input psc_pkg::psc_tx_status_t s, input logic [3:0] c);
    @(negedge clk_in);
    tx_done_out = 1'b1;
    tx_port_out = p;
    tx_len_out = l;
    tx_dest_out = d;
    tx_st_out = s;
    tx_col_out = c;
    @(negedge clk_in);
    tx_done_out = 1'b0;
    // released length and port do not keep the old frame
    tx_len_out = ~l;
    tx_port_out = ~p;
  endtask
  task automatic rx(input logic [2:0] p, input logic [10:0] l, input psc_pkg::psc_dest_t d,
                    input logic f, input logic a, input psc_pkg::psc_rx_drop_t r);
    @(negedge clk_in);
    rx_done_out = 1'b1;
    rx_port_out = p;
    rx_len_out = l;
    rx_dest_out = d;
    rx_fcs_out = f;
    rx_aln_out = a;
    rx_drop_out = r;
    @(negedge clk_in);
    rx_done_out = 1'b0;
    rx_len_out = ~l;
    rx_port_out = ~p;
  endtask
endmodule
`default_nettype wire

/* sim/psc_stats_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_stats_tb;
  logic                    clk, rst_n, ce, en, rq, rv, act, td, rdn, rf, ra;
  logic [2:0]              tp, rp, qp;
  logic [3:0]              tc;
  logic [4:0]              qi;
  logic [10:0]             tl, rl;
  logic [31:0]             rdat;
  psc_pkg::psc_dest_t      tdst, rdst;
  psc_pkg::psc_tx_status_t ts;
  psc_pkg::psc_rx_drop_t   rdr;
  int                      miscompares, n_checks;

  psc_stats uut (.mclk_in(clk), .reset_n_in(rst_n), .ce_in(ce), .stats_enable_in(en),
    .tx_done_in(td), .tx_port_in(tp), .tx_len_in(tl), .tx_dest_in(tdst),
    .tx_status_in(ts), .tx_col_count_in(tc), .rx_done_in(rdn), .rx_port_in(rp),
    .rx_len_in(rl), .rx_dest_in(rdst), .rx_fcs_err_in(rf), .rx_align_err_in(ra),
    .rx_drop_in(rdr), .rd_req_in(rq), .rd_port_in(qp), .rd_index_in(qi),
    .rd_valid_out(rv), .rd_data_out(rdat), .stats_active_out(act));
  psc_mac_model mac (.clk_in(clk), .tx_done_out(td), .tx_port_out(tp), .tx_len_out(tl),
    .tx_dest_out(tdst), .tx_st_out(ts), .tx_col_out(tc), .rx_done_out(rdn),
    .rx_port_out(rp), .rx_len_out(rl), .rx_dest_out(rdst), .rx_fcs_out(rf),
    .rx_aln_out(ra), .rx_drop_out(rdr));

  // ---------------------------------------------------------------
  // checking and read helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [2:0] p, input logic [4:0] i, input logic [31:0] e);
    @(negedge clk);
    rq = 1'b1;
    qp = p;
    qi = i;
    @(negedge clk);
    rq = 1'b0;
    chk("rd_valid", 32'h1, {31'h0, rv});
    chk($sformatf("port %0d counter %0d", p, i), e, rdat);
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic t_reset;
    rd(3'h2, 5'h00, 32'h0);
    chk("stats_active", 32'h1, {31'h0, act});
    $display("test reset done");
  endtask
  task automatic t_tx;
    mac.tx(3'h2, 11'h064, psc_pkg::PSC_DEST_UNI, psc_pkg::PSC_TX_SENT, 4'h1);
    mac.tx(3'h2, 11'h0c8, psc_pkg::PSC_DEST_MULTI, psc_pkg::PSC_TX_SENT, 4'h2);
    mac.tx(3'h2, 11'h040, psc_pkg::PSC_DEST_BCAST, psc_pkg::PSC_TX_SENT, 4'h0);
    for (int s = 1; s < 5; s++) begin
      mac.tx(3'h2, 11'h032, psc_pkg::PSC_DEST_UNI, psc_pkg::psc_tx_status_t'(s), 4'h0);
    end
    rd(3'h2, 5'h00, 32'h16c);
    for (int i = 1; i < 10; i++) begin
      rd(3'h2, 5'(i), 32'h1);
    end
    rd(3'h3, 5'h00, 32'h0);
    $display("test tx done");
  endtask
  task automatic t_rx;
    logic [10:0] l [7] = '{11'h040, 11'h041, 11'h5ee, 11'h5ef, 11'h03f, 11'h7d0, 11'h028};
    logic [1:0]  e [16] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h1, 2'h1, 2'h1,
                            2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1};
    for (int i = 0; i < 7; i++) begin
      mac.rx(3'h5, l[i], i == 1 ? psc_pkg::PSC_DEST_MULTI : i == 2 ? psc_pkg::PSC_DEST_BCAST
             : psc_pkg::PSC_DEST_UNI, i == 1 || i == 5, i == 4, psc_pkg::PSC_RX_KEPT);
    end
    rd(3'h5, 5'h0a, 32'h1495);
    for (int i = 0; i < 16; i++) begin
      rd(3'h5, 5'(i + 11), {30'h0, e[i]});
    end
    mac.rx(3'h6, 11'h0ff, psc_pkg::PSC_DEST_MULTI, 1'b0, 1'b0, psc_pkg::PSC_RX_DROP_BUF);
    mac.rx(3'h6, 11'h3ff, psc_pkg::PSC_DEST_UNI, 1'b0, 1'b0, psc_pkg::PSC_RX_DROP_MEM);
    rd(3'h6, 5'h0a, 32'h4fe);
    rd(3'h6, 5'h0b, 32'h1);
    rd(3'h6, 5'h0c, 32'h1);
    rd(3'h6, 5'h17, 32'h1);
    rd(3'h6, 5'h19, 32'h1);
    $display("test rx done");
  endtask
  task automatic t_both;
    // one tx and one rx event on the same port in the same cycle
    fork
      mac.tx(3'h4, 11'h064, psc_pkg::PSC_DEST_BCAST, psc_pkg::PSC_TX_SENT, 4'h0);
      mac.rx(3'h4, 11'h0c8, psc_pkg::PSC_DEST_MULTI, 1'b0, 1'b0, psc_pkg::PSC_RX_KEPT);
    join
    rd(3'h4, 5'h00, 32'h64);
    rd(3'h4, 5'h03, 32'h1);
    rd(3'h4, 5'h0a, 32'hc8);
    rd(3'h4, 5'h0f, 32'h1);
    rd(3'h4, 5'h17, 32'h1);
    $display("test same-port events done");
  endtask
  task automatic t_rst_mid;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(3'h2, 5'h00, 32'h0);
    rd(3'h5, 5'h0a, 32'h0);
    rd(3'h4, 5'h17, 32'h0);
    chk("stats_active", 32'h1, {31'h0, act});
    $display("test mid-run reset done");
  endtask
  task automatic t_gate;
    en = 1'b0;
    repeat (2) @(negedge clk);
    chk("stats_active", 32'h0, {31'h0, act});
    mac.tx(3'h2, 11'h064, psc_pkg::PSC_DEST_UNI, psc_pkg::PSC_TX_SENT, 4'h0);
    mac.rx(3'h5, 11'h064, psc_pkg::PSC_DEST_UNI, 1'b0, 1'b0, psc_pkg::PSC_RX_KEPT);
    en = 1'b1;
    // let the enable register settle so only ce_in blocks the next event
    repeat (2) @(negedge clk);
    ce = 1'b0;
    mac.rx(3'h5, 11'h064, psc_pkg::PSC_DEST_UNI, 1'b0, 1'b0, psc_pkg::PSC_RX_KEPT);
    ce = 1'b1;
    rd(3'h2, 5'h00, 32'h16c);
    rd(3'h5, 5'h0a, 32'h1495);
    chk("stats_active", 32'h1, {31'h0, act});
    rd(3'h5, 5'h1b, 32'h0);
    $display("test gating done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    {rst_n, rq, qp, qi, miscompares, n_checks} = '0;
    ce = 1'b1;
    en = 1'b1;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_both;
    t_gate;
    t_rst_mid;
    report_and_stop;
  end
endmodule
`default_nettype wire
